/* verilog/audio_clock_pkg.sv */
// Constants, field layouts and carrier types of the audio clock select control.
//
// Behaviour
// - Parallel group pins decode 48, 44.1, 32, reserved
// - Parallel rate pin: low standard, high double
// - Parallel select pin: low 36.864, high 24.576
// - Sampling frequency is group base scaled by rate
// - Audio clocks run at 256x and 384x fs
// - Fixed audio clock always 33.8688 MHz
// - Two buffered master reference copies are provided
// - Half rate and 256x/384x select: serial only
// - Clock settles within 300 ns after change
// - Parallel pin change takes effect within 150 ns
// - Switching is not aligned to output edges
// - Outputs settle about 3 ms after power-on
// - Power-on reset lasts 1024 master clocks
// - Reset loads defaults; outputs run meanwhile
// - Sixteen bits shifted on rising edges, strobe latches
// - Strobe accepted anytime after bit clock stops
// - Mode word prefix, enables, rate and group fields
// - Group field: 00 48, 01 44.1, 10 32
// - Rate field: 00 standard, 01 double, 10 half
// - Each enable bit gates one output clock
// - All enables zero means power-down, serial alive
// - Configuration word bit four halves selectable clock
package audio_clock_pkg;

	localparam int WORD_BITS = 16;
	localparam logic [5:0] MODE_PREFIX = 6'h1c;
	localparam logic [5:0] CONFIG_PREFIX = 6'h1b;
	localparam int PREFIX_POS = 10;
	localparam int ENABLE_POS = 4;
	localparam int RATE_POS = 2;
	localparam int GROUP_POS = 0;
	localparam int HALVING_POS = 4;
	localparam logic [5:0] ENABLE_RESET = 6'h3f;
	localparam logic [1:0] RATE_RESET = 2'h0;
	localparam logic [1:0] GROUP_RESET = 2'h0;
	localparam logic HALVING_RESET = 1'b0;

	localparam int CLOCK_MHZ = 100;
	localparam int POR_MASTER_CLOCKS = 1024;
	localparam int SETTLE_NS = 300;
	localparam int PIN_DELAY_NS = 150;
	localparam int SETTLE_CYCLES = SETTLE_NS * CLOCK_MHZ / 1000;
	localparam int PIN_DELAY_CYCLES = PIN_DELAY_NS * CLOCK_MHZ / 1000;
	localparam int STARTUP_MS = 3;
	// Clocks after reset release before the variant strap has passed its synchroniser.
	localparam int STRAP_SAMPLE_CLOCKS = 2;

	typedef enum logic [1:0] {
		GROUP_48K,
		GROUP_44K1,
		GROUP_32K,
		GROUP_RESERVED
	} group_type;

	typedef enum logic [1:0] {
		RATE_STANDARD,
		RATE_DOUBLE,
		RATE_HALF,
		RATE_RESERVED
	} rate_type;

	// Selectable clock multiple of 48 kHz.
	typedef enum logic [1:0] {
		SEL_768X,
		SEL_512X,
		SEL_384X,
		SEL_256X
	} select_mult_type;

	// Frequency selection delivered to the clock synthesis.
	typedef struct packed {
		group_type group;
		rate_type rate;
		select_mult_type sel_mult;
	} freq_sel_type;

	// Output enables, highest first as in the mode word.
	typedef struct packed {
		logic master_copy_b_enable;
		logic master_copy_a_enable;
		logic selectable_clock_enable;
		logic clock_384x_enable;
		logic clock_256x_enable;
		logic fixed_clock_enable;
	} enables_type;

endpackage

/* verilog/audio_clock_select_control.sv */
// Control logic of the dual-PLL audio clock generator: serial link, mode word and selection.
`timescale 1ns/10ps
`default_nettype none
module audio_clock_select_control (
	// Core clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Serial link, host side
	input wire logic serial_bit_clock_in,
	input wire logic serial_latch_strobe_in,
	input wire logic serial_data_in,
	// Variant strap and parallel select pins
	input wire logic serial_variant_in,
	input wire logic group_select_lo_in,
	input wire logic group_select_hi_in,
	input wire logic rate_select_pin_in,
	input wire logic selectable_clock_pin_in,
	// Control delivered to the synthesis
	output audio_clock_pkg::freq_sel_type freq_sel_out,
	output audio_clock_pkg::enables_type enables_out,
	output logic power_down_out,
	output logic init_done_out,
	output logic settling_out
);
	import audio_clock_pkg::*;

	// ----------------------------------------------------------------
	// Link domain: shifter on the serial bit clock
	// ----------------------------------------------------------------
	// Bits are taken on the rising bit clock edge, MSB first. The word
	// is captured by the core domain when the strobe rises, so a stopped
	// bit clock after the last bit costs nothing.
	logic [WORD_BITS-1:0] shift_word;

	always_ff @(posedge serial_bit_clock_in) begin
		shift_word <= {shift_word[WORD_BITS-2:0], serial_data_in};
	end

	// ----------------------------------------------------------------
	// Core domain state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] strobe_sync;
		logic [WORD_BITS-1:0] word_sync1;
		logic [WORD_BITS-1:0] word_sync2;
		logic [4:0] pin_sync1;
		logic [4:0] pin_sync2;
		logic [10:0] por_count;
		logic init_done;
		logic variant;
		logic variant_taken;
		enables_type enables;
		enables_type shown_enables;
		rate_type rate;
		group_type group;
		logic halving;
		freq_sel_type freq_sel;
		logic power_down;
		logic [7:0] settle_count;
		logic settling;
	} state_type;

	state_type state;
	state_type next_state;

	logic strobe_rise;
	logic [WORD_BITS-1:0] word;
	group_type pin_group;
	rate_type pin_rate;
	freq_sel_type want_sel;
	logic all_off;

	always_comb begin
		next_state = state;
		// The shift word is stable for the whole strobe-high time, so
		// two-stage sampling of each bit yields a coherent word by the
		// time the delayed strobe edge is seen.
		next_state.strobe_sync = {state.strobe_sync[1:0], serial_latch_strobe_in};
		next_state.word_sync1 = shift_word;
		next_state.word_sync2 = state.word_sync1;
		next_state.pin_sync1 = {serial_variant_in, group_select_hi_in, group_select_lo_in,
			rate_select_pin_in, selectable_clock_pin_in};
		next_state.pin_sync2 = state.pin_sync1;
		strobe_rise = state.strobe_sync[1] & ~state.strobe_sync[2];
		word = state.word_sync2;

		if (!state.init_done) begin
			next_state.por_count = state.por_count + 11'h001;
			if (state.por_count == 11'(POR_MASTER_CLOCKS - 1)) begin
				next_state.init_done = 1'b1;
			end
		end
		// The synchroniser is cleared by reset, so the strap is only taken
		// once a real pin sample has reached its second stage.
		if (!state.variant_taken && state.por_count == 11'(STRAP_SAMPLE_CLOCKS)) begin
			next_state.variant = state.pin_sync2[4];
			next_state.variant_taken = 1'b1;
		end

		if (strobe_rise && state.variant && state.init_done) begin
			if (word[WORD_BITS-1:PREFIX_POS] == MODE_PREFIX) begin
				next_state.enables = enables_type'(word[ENABLE_POS+5:ENABLE_POS]);
				next_state.rate = rate_type'(word[RATE_POS+1:RATE_POS]);
				next_state.group = group_type'(word[GROUP_POS+1:GROUP_POS]);
			end else if (word[WORD_BITS-1:PREFIX_POS] == CONFIG_PREFIX) begin
				next_state.halving = word[HALVING_POS];
			end
		end

		// Pin map: [3]=group hi, [2]=group lo, [1]=rate, [0]=select.
		case (state.pin_sync2[3:2])
			2'h0: pin_group = GROUP_48K;
			2'h1: pin_group = GROUP_44K1;
			2'h2: pin_group = GROUP_32K;
			default: pin_group = GROUP_RESERVED;
		endcase
		pin_rate = state.pin_sync2[1] ? RATE_DOUBLE : RATE_STANDARD;

		// Outputs are 256x/384x of group scaled by rate downstream.
		if (state.variant) begin
			want_sel.group = state.group;
			want_sel.rate = state.rate;
			if (state.halving) begin
				want_sel.sel_mult = state.pin_sync2[0] ? SEL_256X : SEL_384X;
			end else begin
				want_sel.sel_mult = state.pin_sync2[0] ? SEL_512X : SEL_768X;
			end
		end else begin
			want_sel.group = pin_group;
			want_sel.rate = pin_rate;
			want_sel.sel_mult = state.pin_sync2[0] ? SEL_512X : SEL_768X;
		end
		// Pins reach the selection within a few cycles, well inside the
		// allowed delay; a switch is not aligned to output edges.
		next_state.freq_sel = want_sel;
		if (want_sel != state.freq_sel) begin
			next_state.settle_count = 8'(SETTLE_CYCLES);
			next_state.settling = 1'b1;
		end else if (state.settle_count != 8'h00) begin
			next_state.settle_count = state.settle_count - 8'h01;
			next_state.settling = (state.settle_count != 8'h01);
		end

		// The parallel variant has no enables; all outputs run. The fixed
		// clock and master copies need no selection.
		all_off = (state.enables == enables_type'(6'h00));
		next_state.power_down = state.variant & all_off;
		next_state.shown_enables = state.variant ? state.enables : enables_type'(ENABLE_RESET);
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			state <= '0;
			state.enables <= enables_type'(ENABLE_RESET);
			state.shown_enables <= enables_type'(ENABLE_RESET);
			state.rate <= rate_type'(RATE_RESET);
			state.group <= group_type'(GROUP_RESET);
			state.halving <= HALVING_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Enables stay at defaults throughout initialization; the selection follows the pins, except serial group and rate.
	// The typical few-millisecond start-up lies in the analog PLLs.
	assign freq_sel_out = state.freq_sel;
	assign enables_out = state.shown_enables;
	assign power_down_out = state.power_down;
	assign init_done_out = state.init_done;
	assign settling_out = state.settling;

endmodule
`default_nettype wire

/* tb/audio_clock_select_control_properties.sv */
// Port checks of the audio clock select control.
`timescale 1ns/10ps
`default_nettype none
module audio_clock_select_control_properties (
	// Watched ports
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic serial_latch_strobe_in,
	input wire logic serial_variant_in,
	input wire logic group_select_lo_in,
	input wire logic group_select_hi_in,
	input wire logic rate_select_pin_in,
	input wire logic selectable_clock_pin_in,
	input wire audio_clock_pkg::freq_sel_type freq_sel_out,
	input wire audio_clock_pkg::enables_type enables_out,
	input wire logic power_down_out,
	input wire logic init_done_out,
	input wire logic settling_out
);
	import audio_clock_pkg::*;
	logic [10:0] since_reset;
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!nrst_in);
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in)
			since_reset <= 11'h000;
		else if (since_reset != 11'h7ff)
			since_reset <= since_reset + 11'h001;
	end
	reset_defaults_a: assert property (disable iff (1'b0) !nrst_in |=>
		freq_sel_out == 6'h00 && enables_out == 6'h3f && !init_done_out && !power_down_out)
		else $error("outputs not at defaults after reset");
	init_count_a: assert property ($rose(init_done_out) |->
		since_reset >= 11'h400 && since_reset <= 11'h406)
		else $error("init done at wrong count");
	strobe_cause_a: assert property ($changed(enables_out) |->
		$past(serial_latch_strobe_in, 3))
		else $error("enables changed without strobe");
	power_down_a: assert property (enables_out == 6'h00 && serial_variant_in |->
		##[0:1] power_down_out)
		else $error("no power down with all enables clear");
	parallel_enables_a: assert property (init_done_out && !serial_variant_in |->
		enables_out == 6'h3f && !power_down_out)
		else $error("parallel variant output gated");
	rate_pin_a: assert property (!serial_variant_in && $changed(rate_select_pin_in) |->
		##[1:15] freq_sel_out[3:2] == {1'b0, rate_select_pin_in})
		else $error("rate pin not followed");
	group_pin_a: assert property (!serial_variant_in &&
		$changed({group_select_hi_in, group_select_lo_in}) |->
		##[1:15] freq_sel_out[5:4] == {group_select_hi_in, group_select_lo_in})
		else $error("group pins not followed");
	select_pin_a: assert property (!serial_variant_in && $changed(selectable_clock_pin_in) |->
		##[1:15] freq_sel_out[1:0] == {1'b0, selectable_clock_pin_in})
		else $error("select pin not followed");
	settle_flag_a: assert property ($past(nrst_in) && $changed(freq_sel_out) |->
		settling_out)
		else $error("selection changed without settling flag");
	settle_time_a: assert property ($fell(settling_out) |->
		$past(freq_sel_out, 30) == freq_sel_out && $past(freq_sel_out, 31) != freq_sel_out)
		else $error("settling window of wrong length");
endmodule
bind audio_clock_select_control audio_clock_select_control_properties checker_inst (.*);
`default_nettype wire

/* tb/serial_host_model.sv */
// Host that writes words over the three-wire serial link.
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
	// Serial link toward the device
	output logic bit_clock_out,
	output logic strobe_out,
	output logic data_out
);
	initial begin
		bit_clock_out = 1'b0;
		strobe_out = 1'b0;
		data_out = 1'b0;
	end
	// The bit clock stands still between words; data falls to the pull-down level.
	task automatic send(input logic [15:0] word);
		#7;
		for (int b = 15; b >= 0; b--) begin
			data_out = word[b];
			#15 bit_clock_out = 1'b1;
			#15 bit_clock_out = 1'b0;
		end
		data_out = 1'b0;
		#40 strobe_out = 1'b1;
		#250 strobe_out = 1'b0;
	endtask
endmodule
`default_nettype wire

/* tb/audio_clock_select_control_bench.sv */
// Self-checking bench of the audio clock select control.
`timescale 1ns/10ps
`default_nettype none
module audio_clock_select_control_bench;
	import audio_clock_pkg::*;
	logic ref_clk_in = '0, nrst_in = '0, serial_variant_in = '1;
	logic group_select_lo_in = '0, group_select_hi_in = '0;
	logic rate_select_pin_in = '0, selectable_clock_pin_in = '0;
	wire logic serial_bit_clock_in, serial_latch_strobe_in, serial_data_in;
	freq_sel_type freq_sel_out;
	enables_type enables_out;
	logic power_down_out, init_done_out, settling_out;
	int n_errors = 0, compares = 0, seed = 87897, g, r, k;
	logic [5:0] e;
	always #5 ref_clk_in = ~ref_clk_in;
	serial_host_model host (.bit_clock_out(serial_bit_clock_in),
		.strobe_out(serial_latch_strobe_in), .data_out(serial_data_in));
	audio_clock_select_control dut (.*);
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	task automatic chk(input logic [11:0] seen, input logic [11:0] want);
		compares++;
		if (seen !== want) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask
	// Expectation is rebuilt from what the bench last wrote, never from outputs.
	task automatic expect_state(input logic [1:0] mult);
		chk({freq_sel_out, enables_out}, {g[1:0], r[1:0], mult, e});
	endtask
	task automatic put(input logic [15:0] word);
		host.send(word);
		tick(40);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic boot(input logic serial);
		nrst_in <= 1'b0;
		serial_variant_in <= serial;
		selectable_clock_pin_in <= 1'b0;
		g = 0;
		r = 0;
		e = 6'h3f;
		tick(10);
		expect_state(2'h0);
		nrst_in <= 1'b1;
		put({MODE_PREFIX, 10'h002});
		expect_state(2'h0);
		for (k = 0; k < 1200 && init_done_out !== 1'b1; k++)
			tick(1);
		if (init_done_out !== 1'b1) begin
			n_errors++;
			tally_and_finish;
		end
	endtask
	initial begin
		boot(1'b1);
		for (g = 0; g < 3; g++)
			for (r = 0; r < 3; r++) begin
				e = 6'($random(seed)) | 6'h01;
				put({MODE_PREFIX, e, r[1:0], g[1:0]});
				expect_state(2'h0);
			end
		g = 2;
		r = 2;
		put({6'h3f, 10'h000});
		expect_state(2'h0);
		put({CONFIG_PREFIX, 10'h010});
		for (k = 0; k < 2; k++) begin
			selectable_clock_pin_in <= k[0];
			tick(20);
			expect_state({1'b1, k[0]});
		end
		g = 0;
		r = 0;
		e = 6'h00;
		put({MODE_PREFIX, 10'h000});
		chk({11'h000, power_down_out}, 12'h001);
		e = 6'h3f;
		put({MODE_PREFIX, 10'h3f0});
		chk({11'h000, power_down_out}, 12'h000);
		expect_state(2'h3);
		boot(1'b0);
		for (k = 0; k < 16; k++) begin
			{group_select_hi_in, group_select_lo_in} <= k[3:2];
			{rate_select_pin_in, selectable_clock_pin_in} <= k[1:0];
			g = k[3:2];
			r = k[1];
			tick(20);
			expect_state({1'b0, k[0]});
			chk({11'h000, settling_out}, {11'h000, (k != 0)});
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
